// *** low_decode_cfg.svh ***
// offsets, field positions, reset values and fixed windows of the low memory decoder
// assumes: included by bare name from the decoder package or module
`ifndef LOW_DECODE_CFG_SVH
`define LOW_DECODE_CFG_SVH
// register byte offsets
`define OFS_ATTR      8'h00
`define OFS_CTRL      8'h04
`define OFS_MEMTOP    8'h08
`define OFS_STATUS    8'h0C
`define OFS_WIN_FIRST 8'h10
`define OFS_WIN_LAST  8'h40
// attribute register: read enables low, write enables high
`define ATTR_RE_LSB   0
`define ATTR_WE_LSB   16
// control register fields
`define CTRL_HOLE     0
`define CTRL_SMM_EN   1
`define CTRL_SMM_SZ   2
`define CTRL_EXT_SMR  4
`define CTRL_GFX_EN   5
`define CTRL_ENG_EN   6
`define CTRL_PORT_EN  7
`define CTRL_GRD_LSB  8
`define CTRL_GRD_EN   16
// memory top register: low dram top and stolen size, both in MB
`define MT_TOP_LSB    0
`define MT_STOL_LSB   16
// reset values
`define ATTR_RST      32'h0000_0000
`define CTRL_RST      32'h0000_0000
`define MEMTOP_RST    32'h0000_0200
`define WIN_RST       32'h0000_0000
// legacy shadow area
`define SHADOW_LO     32'h000C_0000
`define SYSBIOS_LO    32'h000F_0000
`define ONE_MB        32'h0010_0000
`define SEG_SHIFT     14
`define SYSBIOS_SEG   4'hC
// isa hole, MB units
`define HOLE_LO_MB    12'h00F
`define HOLE_HI_MB    12'h010
// window index order and address masks
`define WIN_EGRESS    4'h0
`define WIN_CTLREG    4'h1
`define WIN_HUBREG    4'h2
`define WIN_FLATCFG   4'h3
`define WIN_APERT     4'h4
`define WIN_TABLE     4'h5
`define WIN_GREG0     4'h6
`define WIN_GREG1     4'h7
`define WIN_ENGKT     4'h8
`define WIN_PMEM_B    4'h9
`define WIN_PMEM_L    4'hA
`define WIN_PREF_B    4'hB
`define WIN_PREF_L    4'hC
`define MSK_4K        32'hFFFF_F000
`define MSK_16K       32'hFFFF_C000
`define MSK_256M      32'hF000_0000
`define MSK_256K      32'hFFFC_0000
`define MSK_512K      32'hFFF8_0000
`define MSK_8B        32'hFFFF_FFF8
`endif

// *** low_decode_pkg.sv ***
// types shared by the low memory decoder
// assumes: constants come from low_decode_cfg.svh
package low_decode_pkg;
   typedef enum logic [2:0] {
      DST_DRAM    = 3'b000,
      DST_HUB     = 3'b001,
      DST_PORT    = 3'b010,
      DST_GFX     = 3'b011,
      DST_INTREG  = 3'b100,
      DST_CONFIG  = 3'b101,
      DST_ENGINE  = 3'b110,
      DST_INVALID = 3'b111
   } dest_t;
   typedef enum logic [1:0] {
      SRC_CPU  = 2'b00,
      SRC_PORT = 2'b01,
      SRC_HUB  = 2'b10,
      SRC_GFX  = 2'b11
   } src_t;
   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_HUNG = 1'b1
   } run_t;
endpackage : low_decode_pkg

// *** legacy_and_low_memory_decoder.sv ***
// request router for the shadow bios area, low main memory and pci memory below 4 GB
// assumes: one clock, requests synchronous to mclk, registers set over APB
//
// Overview of operation
// - four 16 KB extended bios segments, each read/write attribute picks dram or hub
// - disabled shadow segment never relocates its dram elsewhere
// - non-snooped port or hub accesses to shadow area always go to dram
// - top 64 KB bios segment resets disabled, so cycles go to hub
// - thirteen segments from 768 KB to 1 MB, attributes applied independently
// - processor or hub access to a disabled direction defaults to hub
// - implicit writeback headed for hub hangs the decoder
// - 1 MB to low dram top goes to dram except smm, guard, hole, stolen
// - with hole enabled, 15 MB to 16 MB goes to hub, dram unreachable
// - smm top segment is 1, 2 or 8 MB directly below stolen memory
// - smm processor accesses to smm segment reach dram untranslated
// - non-processor smm hits become invalid, address zero, write enables off
// - extended smram: processor access lacking smm or writeback is invalid
// - writeback hits on smm segment outside smm complete to dram
// - all dma into the guard window is blocked, window up to 255 MB
// - guard window top sits one byte below smm segment base
// - low dram top to 4 GB goes to hub except register, config, port, graphics and engine windows
// - port memory and prefetch base/limit hits go to the port
// - flat config window hits decode bus, device and function
// - graphics enabled: aperture, table and both register windows go to graphics
// - engine enabled: keyboard text window is decoded as an exception
// - memory decode wins over overlapping windows, no interlock
`timescale 1ns/100ps
`include "low_decode_cfg.svh"
module legacy_and_low_memory_decoder #(
   parameter int NUM_SEG = 13,
   parameter int NUM_WIN = 13
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        reqValid,
   input  wire logic [31:0] reqAddr,
   input  wire logic [1:0]  reqSrc,
   input  wire logic        reqWrite,
   input  wire logic [7:0]  reqBe,
   input  wire logic        reqSnoop,
   input  wire logic        reqSmm,
   input  wire logic        reqWb,
   input  wire logic        reqImplicitWb,
   output logic             reqReady,
   output logic             rspValid,
   output logic      [2:0]  rspDest,
   output logic      [31:0] rspAddr,
   output logic      [7:0]  rspBe,
   output logic      [7:0]  rspCfgBus,
   output logic      [4:0]  rspCfgDev,
   output logic      [2:0]  rspCfgFn
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic winHit(input logic [31:0] a, input logic [31:0] b,
                                   input logic [31:0] m);
      winHit = b[0] && (((a ^ b) & m) == 32'h0000_0000);
   endfunction : winHit

   function automatic logic inShadow(input logic [31:0] a);
      inShadow = (a >= `SHADOW_LO) && (a < `ONE_MB);
   endfunction : inShadow

   function automatic logic [11:0] smmSizeMb(input logic [1:0] code);
      case (code)
         2'h1:    smmSizeMb = 12'h002;
         2'h2:    smmSizeMb = 12'h008;
         default: smmSizeMb = 12'h001;
      endcase
   endfunction : smmSizeMb

   function automatic logic [31:0] winMask(input logic [3:0] idx);
      case (idx)
         `WIN_CTLREG:  winMask = `MSK_16K;
         `WIN_FLATCFG: winMask = `MSK_256M;
         `WIN_APERT:   winMask = `MSK_256M;
         `WIN_TABLE:   winMask = `MSK_256K;
         `WIN_GREG0:   winMask = `MSK_512K;
         `WIN_GREG1:   winMask = `MSK_512K;
         `WIN_ENGKT:   winMask = `MSK_8B;
         default:      winMask = `MSK_4K;
      endcase
   endfunction : winMask

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] attr;
   logic [31:0] ctrl;
   logic [31:0] memTop;
   logic [31:0] win [NUM_WIN];
   low_decode_pkg::run_t runState;
   logic [2:0]  lastDest;

   logic        setup;
   logic        wrDone;
   logic        regOk;
   logic [3:0]  winIdx;
   logic [7:0]  winOfs;
   logic [31:0] rdMux;

   assign setup  = psel && !penable;
   assign wrDone = psel && penable && pready && pwrite;
   assign winOfs = paddr - `OFS_WIN_FIRST;
   assign winIdx = winOfs[5:2];

   always_comb begin
      regOk = (paddr[1:0] == 2'b00) && (paddr <= `OFS_WIN_LAST);
      rdMux = 32'h0000_0000;
      case (paddr)
         `OFS_ATTR:   rdMux = attr;
         `OFS_CTRL:   rdMux = ctrl;
         `OFS_MEMTOP: rdMux = memTop;
         `OFS_STATUS: rdMux = {28'h0000000, lastDest, runState == low_decode_pkg::ST_HUNG};
         default: begin
            if (regOk) begin
               rdMux = win[winIdx];
            end
         end
      endcase
   end

   // two-cycle access phase so pready and prdata come from flops
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         if (setup) begin
            prdata <= regOk ? rdMux : 32'h0000_0000;
         end
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !regOk;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         attr   <= `ATTR_RST;
         ctrl   <= `CTRL_RST;
         memTop <= `MEMTOP_RST;
         for (int i = 0; i < NUM_WIN; i++) begin
            win[i] <= `WIN_RST;
         end
      end else if (wrDone && regOk) begin
         case (paddr)
            `OFS_ATTR:   attr   <= pwdata;
            `OFS_CTRL:   ctrl   <= pwdata;
            `OFS_MEMTOP: memTop <= pwdata;
            `OFS_STATUS: ;
            default:     win[winIdx] <= pwdata;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decode, all compares on settings as they stand at acceptance
   logic        accept;
   logic [11:0] mb;
   logic [11:0] lowTop;
   logic [11:0] stolenBase;
   logic [11:0] smmBase;
   logic [11:0] guardBase;
   logic [3:0]  seg;
   logic        segOn;
   logic        fromDma;
   logic        hitSmm;
   logic        hitGuard;
   logic        hitStolen;
   logic        hitHole;
   low_decode_pkg::dest_t next_dest;
   logic [31:0] next_addr;
   logic [7:0]  next_be;

   assign accept  = reqValid && reqReady;
   assign mb      = reqAddr[31:20];
   assign lowTop  = memTop[`MT_TOP_LSB +: 12];
   assign fromDma = reqSrc != low_decode_pkg::SRC_CPU;
   // stolen memory exists only with graphics enabled; smm segment sits below it
   assign stolenBase = ctrl[`CTRL_GFX_EN] ? lowTop - {4'h0, memTop[`MT_STOL_LSB +: 8]}
                                          : lowTop;
   assign smmBase    = stolenBase - smmSizeMb(ctrl[`CTRL_SMM_SZ +: 2]);
   // guard top is smmBase minus one byte whether or not the segment is on
   assign guardBase  = smmBase - {4'h0, ctrl[`CTRL_GRD_LSB +: 8]};
   assign hitSmm     = ctrl[`CTRL_SMM_EN] && (mb >= smmBase) && (mb < stolenBase);
   assign hitGuard   = ctrl[`CTRL_GRD_EN] && (mb >= guardBase) && (mb < smmBase);
   assign hitStolen  = (mb >= stolenBase) && (mb < lowTop);
   assign hitHole    = ctrl[`CTRL_HOLE] && (mb >= `HOLE_LO_MB) && (mb < `HOLE_HI_MB);
   // system bios area is one segment, the rest are 16 KB each
   assign seg   = (reqAddr >= `SYSBIOS_LO) ? `SYSBIOS_SEG
                                           : 4'((reqAddr - `SHADOW_LO) >> `SEG_SHIFT);
   assign segOn = reqWrite ? attr[`ATTR_WE_LSB + seg] : attr[`ATTR_RE_LSB + seg];

   always_comb begin
      next_dest = low_decode_pkg::DST_HUB;
      next_addr = reqAddr;
      next_be   = reqBe;
      if (inShadow(reqAddr)) begin
         if ((reqSrc == low_decode_pkg::SRC_PORT || reqSrc == low_decode_pkg::SRC_HUB)
             && !reqSnoop) begin
            next_dest = low_decode_pkg::DST_DRAM;
         end else if (segOn) begin
            next_dest = low_decode_pkg::DST_DRAM;
         end else begin
            // disabled dram is simply not reachable, no alias elsewhere
            next_dest = low_decode_pkg::DST_HUB;
         end
      end else if (reqAddr >= `ONE_MB && mb < lowTop) begin
         next_dest = low_decode_pkg::DST_DRAM;
         if (hitHole) begin
            next_dest = low_decode_pkg::DST_HUB;
         end else if (hitSmm) begin
            if (fromDma) begin
               next_dest = low_decode_pkg::DST_INVALID;
            end else if (ctrl[`CTRL_EXT_SMR] && !(reqSmm && reqWb)) begin
               next_dest = low_decode_pkg::DST_INVALID;
            end else if (reqSmm || reqWb) begin
               next_dest = low_decode_pkg::DST_DRAM;
            end else begin
               next_dest = low_decode_pkg::DST_INVALID;
            end
         end else if (hitGuard && fromDma) begin
            next_dest = low_decode_pkg::DST_INVALID;
         end else if (hitStolen && reqSrc != low_decode_pkg::SRC_GFX) begin
            next_dest = low_decode_pkg::DST_INVALID;
         end
      end else if (mb >= lowTop) begin
         if (winHit(reqAddr, win[`WIN_EGRESS], winMask(`WIN_EGRESS)) ||
             winHit(reqAddr, win[`WIN_CTLREG], winMask(`WIN_CTLREG)) ||
             winHit(reqAddr, win[`WIN_HUBREG], winMask(`WIN_HUBREG))) begin
            next_dest = low_decode_pkg::DST_INTREG;
         end else if (winHit(reqAddr, win[`WIN_FLATCFG], winMask(`WIN_FLATCFG))) begin
            next_dest = low_decode_pkg::DST_CONFIG;
         end else if (ctrl[`CTRL_PORT_EN] &&
                      ((mb >= win[`WIN_PMEM_B][31:20] && mb <= win[`WIN_PMEM_L][31:20]) ||
                       (mb >= win[`WIN_PREF_B][31:20] && mb <= win[`WIN_PREF_L][31:20]))) begin
            next_dest = low_decode_pkg::DST_PORT;
         end else if (ctrl[`CTRL_GFX_EN] &&
                      (winHit(reqAddr, win[`WIN_APERT], winMask(`WIN_APERT)) ||
                       winHit(reqAddr, win[`WIN_TABLE], winMask(`WIN_TABLE)) ||
                       winHit(reqAddr, win[`WIN_GREG0], winMask(`WIN_GREG0)) ||
                       winHit(reqAddr, win[`WIN_GREG1], winMask(`WIN_GREG1)))) begin
            next_dest = low_decode_pkg::DST_GFX;
         end else if (ctrl[`CTRL_ENG_EN] &&
                      winHit(reqAddr, win[`WIN_ENGKT], winMask(`WIN_ENGKT))) begin
            next_dest = low_decode_pkg::DST_ENGINE;
         end
      end
      if (next_dest == low_decode_pkg::DST_INVALID) begin
         next_addr = 32'h0000_0000;
         next_be   = reqWrite ? 8'h00 : reqBe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // no recovery from a hub-bound implicit writeback except reset
   logic wbToHub;
   assign wbToHub = accept && reqImplicitWb && next_dest == low_decode_pkg::DST_HUB;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         runState <= low_decode_pkg::ST_RUN;
         reqReady <= 1'b1;
      end else begin
         case (runState)
            low_decode_pkg::ST_RUN: begin
               if (wbToHub) begin
                  runState <= low_decode_pkg::ST_HUNG;
                  reqReady <= 1'b0;
               end
            end
            low_decode_pkg::ST_HUNG: reqReady <= 1'b0;
            default: begin
               runState <= low_decode_pkg::ST_RUN;
               reqReady <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rspValid  <= 1'b0;
         rspDest   <= low_decode_pkg::DST_HUB;
         rspAddr   <= 32'h0000_0000;
         rspBe     <= 8'h00;
         rspCfgBus <= 8'h00;
         rspCfgDev <= 5'h00;
         rspCfgFn  <= 3'h0;
         lastDest  <= low_decode_pkg::DST_HUB;
      end else begin
         rspValid <= accept && !wbToHub;
         if (accept && !wbToHub) begin
            rspDest   <= next_dest;
            rspAddr   <= next_addr;
            rspBe     <= next_be;
            rspCfgBus <= reqAddr[27:20];
            rspCfgDev <= reqAddr[19:15];
            rspCfgFn  <= reqAddr[14:12];
            lastDest  <= next_dest;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_wb_to_hub;
      wbToHub;
   endsequence
   sequence s_stay_hung;
      (!reqReady && !rspValid) [*3];
   endsequence
   property p_wb_hung;
      s_wb_to_hub |=> s_stay_hung;
   endproperty

   a_shadow_nosnoop: assert property (@(posedge mclk) disable iff (!arst_n)
      accept && inShadow(reqAddr) && !reqSnoop &&
      (reqSrc == low_decode_pkg::SRC_PORT || reqSrc == low_decode_pkg::SRC_HUB)
      |=> rspValid && rspDest == low_decode_pkg::DST_DRAM)
      else $error("shadow dma not to dram");

   // a hub-bound implicit writeback hangs instead of answering, so it is left out here
   a_shadow_default: assert property (@(posedge mclk) disable iff (!arst_n)
      accept && inShadow(reqAddr) && !segOn && reqSrc == low_decode_pkg::SRC_CPU &&
      !reqImplicitWb |=> rspDest == low_decode_pkg::DST_HUB)
      else $error("disabled segment not to hub");

   a_bios_reset: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(arst_n) |-> attr == 32'h0000_0000)
      else $error("attributes not cleared");

   a_hole_hub: assert property (@(posedge mclk) disable iff (!arst_n)
      accept && hitHole && mb < lowTop && !reqImplicitWb
      |=> rspDest == low_decode_pkg::DST_HUB)
      else $error("hole not sent to hub");

   a_smm_cpu_dram: assert property (@(posedge mclk) disable iff (!arst_n)
      accept && hitSmm && !hitHole && reqSrc == low_decode_pkg::SRC_CPU && reqSmm && reqWb
      |=> rspDest == low_decode_pkg::DST_DRAM && rspAddr == $past(reqAddr))
      else $error("smm access translated");

   a_smm_dma_invalid: assert property (@(posedge mclk) disable iff (!arst_n)
      accept && hitSmm && !hitHole && fromDma && reqWrite |=> rspDest ==
      low_decode_pkg::DST_INVALID && rspAddr == 32'h0000_0000 && rspBe == 8'h00)
      else $error("dma smm hit not invalidated");

   a_ext_smram: assert property (@(posedge mclk) disable iff (!arst_n)
      accept && hitSmm && !hitHole && !fromDma && ctrl[`CTRL_EXT_SMR] && !reqSmm
      |=> rspDest == low_decode_pkg::DST_INVALID)
      else $error("ext smram not enforced");

   a_guard_block: assert property (@(posedge mclk) disable iff (!arst_n)
      accept && hitGuard && fromDma && !hitHole && !hitSmm && reqAddr >= `ONE_MB && mb < lowTop
      |=> rspDest == low_decode_pkg::DST_INVALID)
      else $error("guard window not blocked");

   a_wb_hang: assert property (@(posedge mclk) disable iff (!arst_n) p_wb_hung)
      else $error("decoder not hung");

   a_pci_default: assert property (@(posedge mclk) disable iff (!arst_n)
      accept && mb >= lowTop && !ctrl[`CTRL_PORT_EN] && !ctrl[`CTRL_GFX_EN] &&
      !ctrl[`CTRL_ENG_EN] && !win[`WIN_EGRESS][0] && !win[`WIN_CTLREG][0] &&
      !win[`WIN_HUBREG][0] && !win[`WIN_FLATCFG][0] && !reqImplicitWb
      |=> rspDest == low_decode_pkg::DST_HUB)
      else $error("pci range not to hub");

endmodule : legacy_and_low_memory_decoder

// *** requester_model.sv ***
// requester model: issues one memory request at a time and collects its answer
// assumes: the decoder takes a request on the rising mclk edge with reqValid and reqReady
`timescale 1ns/100ps
module requester_model (
   input  wire logic        mclk,
   output logic             reqValid,
   output logic      [31:0] reqAddr,
   output logic      [1:0]  reqSrc,
   output logic             reqWrite,
   output logic      [7:0]  reqBe,
   output logic             reqSnoop,
   output logic             reqSmm,
   output logic             reqWb,
   output logic             reqImplicitWb,
   input  wire logic        reqReady,
   input  wire logic        rspValid,
   input  wire logic [2:0]  rspDest,
   input  wire logic [31:0] rspAddr,
   input  wire logic [7:0]  rspBe
);
   initial begin
      {reqValid, reqWrite, reqSnoop, reqSmm, reqWb, reqImplicitWb} = '0;
      {reqAddr, reqSrc, reqBe} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // f = {write, snoop, smm, writeback, implicit writeback}; idle lets a caller be slow
   task automatic issue(input int idle, input logic [31:0] a, input logic [1:0] s,
                        input logic [4:0] f, output logic ok, output logic [2:0] d,
                        output logic [31:0] ra, output logic [7:0] rb);
      ok = 1'b0;
      repeat (idle) @(posedge mclk);
      @(posedge mclk);
      reqValid <= 1'b1;
      reqAddr  <= a;
      reqSrc   <= s;
      reqBe    <= 8'hFF;
      {reqWrite, reqSnoop, reqSmm, reqWb, reqImplicitWb} <= f;
      // held until the edge that samples reqReady high; only the bench watchdog ends a wait
      do begin
         @(posedge mclk);
      end while (reqReady !== 1'b1);
      reqValid <= 1'b0;
      // released address toggles so a stale value is never mistaken for a live one
      reqAddr  <= ~a;
      @(negedge mclk);
      ok = (rspValid === 1'b1);
      d  = rspDest;
      ra = rspAddr;
      rb = rspBe;
   endtask : issue
endmodule : requester_model

// *** legacy_and_low_memory_decoder_tb.sv ***
// self-checking bench for the low memory decoder: APB setup, then routed requests
// assumes: requester_model drives the request side, 50 MHz mclk
`timescale 1ns/100ps
module legacy_and_low_memory_decoder_tb;
   localparam logic [2:0] DRAM = low_decode_pkg::DST_DRAM;
   localparam logic [2:0] HUB  = low_decode_pkg::DST_HUB;
   localparam logic [2:0] INV  = low_decode_pkg::DST_INVALID;
   localparam logic [1:0] CPU  = low_decode_pkg::SRC_CPU;
   localparam logic [1:0] PRT  = low_decode_pkg::SRC_PORT;
   localparam logic [1:0] HB   = low_decode_pkg::SRC_HUB;
   localparam logic [1:0] GX   = low_decode_pkg::SRC_GFX;
   localparam logic [4:0] RD = 5'h00, WR = 5'h10, SNP = 5'h08, SYSTEM_MANAGEMENT_MODE = 5'h04, WB = 5'h02;
   logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, reqBe, rspBe, rspCfgBus;
   logic [31:0] pwdata, prdata, reqAddr, rspAddr;
   logic [1:0]  reqSrc;
   logic [2:0]  rspDest, rspCfgFn;
   logic [4:0]  rspCfgDev;
   logic        reqValid, reqWrite, reqSnoop, reqSmm, reqWb, reqImplicitWb;
   logic        reqReady, rspValid;
   int          nErrors = 0;
   int          checkCount = 0;

   legacy_and_low_memory_decoder i_dut (.*);
   requester_model i_req (.mclk(mclk), .reqValid(reqValid), .reqAddr(reqAddr),
      .reqSrc(reqSrc), .reqWrite(reqWrite), .reqBe(reqBe), .reqSnoop(reqSnoop),
      .reqSmm(reqSmm), .reqWb(reqWb), .reqImplicitWb(reqImplicitWb), .reqReady(reqReady),
      .rspValid(rspValid), .rspDest(rspDest), .rspAddr(rspAddr), .rspBe(rspBe));

   always #10 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0, "write error");
   endtask : wr

   task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, "read data");
      chk({31'h0, e}, {31'h0, expErr}, "slave error");
   endtask : rdx

   // invalid cycles carry address zero; invalid writes also lose their byte enables
   task automatic rq(input logic [31:0] a, input logic [1:0] s, input logic [4:0] f,
                     input logic [2:0] dest);
      logic        ok;
      logic [2:0]  d;
      logic [31:0] ra;
      logic [7:0]  rb;
      i_req.issue(0, a, s, f, ok, d, ra, rb);
      chk({31'h0, ok}, 32'h1, "response");
      chk({29'h0, d}, {29'h0, dest}, "destination");
      chk(ra, (dest == INV) ? 32'h0 : a, "address");
      chk({24'h0, rb}, (dest == INV && f[4]) ? 32'h0 : 32'hFF, "byte enables");
   endtask : rq

   task automatic conclude();
      $display("checks %0d mismatches %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic        ok;
      logic [2:0]  d;
      logic [31:0] ra, sz;
      logic [7:0]  rb;
      logic [31:0] g [4];
      logic        e;
      mclk = 1'b0;
      arst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      rdx(8'h00, 32'h0, 1'b0);
      rdx(8'h08, 32'h0000_0200, 1'b0);
      rdx(8'h80, 32'h0, 1'b1);
      rdx(8'h02, 32'h0, 1'b1);
      rq(32'h000F_0000, CPU, RD, HUB);
      rq(32'h000F_FFF0, HB, WR | SNP, HUB);
      rq(32'h000E_4000, PRT, RD, DRAM);
      rq(32'h000D_0000, HB, WR, DRAM);
      rq(32'h4000_0000, CPU, RD, HUB);
      for (int n = 0; n < 13; n++) begin
         wr(8'h00, 32'h1 << n);
         rq(32'h000C_0000 + (n << 14), CPU, RD, DRAM);
         rq(32'h000C_0000 + (n << 14), CPU, WR, HUB);
         rq(32'h000C_0000 + (((n + 1) % 13) << 14), HB, SNP, HUB);
      end
      wr(8'h00, 32'h1FFF_0000);
      rq(32'h000F_FFF0, CPU, WR, DRAM);
      rq(32'h0010_0000, CPU, RD, DRAM);
      rq(32'h00F0_0000, PRT, WR, DRAM);
      wr(8'h04, 32'h0000_0001);
      rq(32'h00F0_0000, CPU, RD, HUB);
      rq(32'h00FF_FFF8, HB, WR, HUB);
      rq(32'h0100_0000, CPU, RD, DRAM);
      rq(32'h00EF_FFF8, CPU, RD, DRAM);
      for (int k = 0; k < 3; k++) begin
         sz = (k == 2) ? 32'h8 : k + 1;
         wr(8'h04, 32'h3 | (k << 2));
         rq(32'h2000_0000 - (sz << 20), PRT, RD, INV);
         rq(32'h1FFF_FFF8 - (sz << 20), PRT, RD, DRAM);
      end
      wr(8'h04, 32'h0000_0003);
      rq(32'h1FF0_0040, CPU, SYSTEM_MANAGEMENT_MODE, DRAM);
      rq(32'h1FF0_0040, PRT, WR, INV);
      rq(32'h1FF0_0040, HB, RD, INV);
      rq(32'h1FF0_0040, GX, WR | SYSTEM_MANAGEMENT_MODE, INV);
      rq(32'h1FF0_0040, CPU, WB | WR, DRAM);
      wr(8'h04, 32'h0000_0013);
      rq(32'h1FF0_0040, CPU, SYSTEM_MANAGEMENT_MODE, INV);
      rq(32'h1FF0_0040, CPU, WB | WR, INV);
      rq(32'h1FF0_0040, CPU, SYSTEM_MANAGEMENT_MODE | WB, DRAM);
      wr(8'h04, 32'h0001_0203);
      rq(32'h1FD0_0000, PRT, RD, INV);
      rq(32'h1FEF_FFF8, GX, WR, INV);
      rq(32'h1FCF_FFF8, PRT, RD, DRAM);
      rq(32'h1FD0_0000, CPU, RD, DRAM);
      wr(8'h04, 32'h0001_0200);
      rq(32'h1FEF_FFF8, HB, RD, INV);
      rq(32'h1FF0_0000, HB, RD, DRAM);
      wr(8'h04, 32'h0001_FF03);
      rq(32'h1000_0000, PRT, RD, INV);
      rq(32'h0FFF_FFF8, PRT, RD, DRAM);
      // windows kept clear of the interrupt, apic and high bios areas
      wr(8'h04, 32'h0000_00E0);
      wr(8'h10, 32'hE000_0001);
      wr(8'h1C, 32'hC000_0001);
      wr(8'h20, 32'h9000_0001);
      wr(8'h24, 32'hD800_0001);
      wr(8'h28, 32'hD810_0001);
      wr(8'h2C, 32'hD818_0001);
      wr(8'h30, 32'hE100_0001);
      wr(8'h34, 32'hA000_0000);
      wr(8'h38, 32'hA0F0_0000);
      rq(32'h8000_0000, CPU, RD, HUB);
      rq(32'hE000_0FF0, CPU, RD, low_decode_pkg::DST_INTREG);
      rq(32'hE000_1000, CPU, RD, HUB);
      rq(32'hC123_4000, CPU, RD, low_decode_pkg::DST_CONFIG);
      chk({16'h0, rspCfgBus, rspCfgDev, rspCfgFn}, 32'h0000_1234, "cfg");
      rq(32'hA0FF_FFF0, CPU, WR, low_decode_pkg::DST_PORT);
      rq(32'hA100_0000, CPU, WR, HUB);
      g = '{32'h9000_1000, 32'hD803_FFF0, 32'hD817_FFF0, 32'hD818_0000};
      foreach (g[i]) rq(g[i], CPU, RD, low_decode_pkg::DST_GFX);
      rq(32'hE100_0004, CPU, RD, low_decode_pkg::DST_ENGINE);
      rq(32'hE100_0008, CPU, RD, HUB);
      wr(8'h04, 32'h0000_0000);
      rq(32'h9000_1000, CPU, RD, HUB);
      rq(32'hE100_0004, CPU, RD, HUB);
      rq(32'hA000_0000, CPU, RD, HUB);
      wr(8'h14, 32'h0800_0001);
      rq(32'h0800_0010, CPU, RD, DRAM);
      wr(8'h00, 32'h0000_0000);
      i_req.issue(2, 32'h000C_0000, HB, SNP | 5'h01, ok, d, ra, rb);
      chk({31'h0, ok}, 32'h0, "hung response");
      @(negedge mclk);
      chk({31'h0, reqReady}, 32'h0, "ready after hang");
      apb(1'b0, 8'h0C, 32'h0, ra, e);
      chk(ra, 32'h0000_0001, "hang status");
      conclude();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      nErrors++;
      conclude();
   end
endmodule : legacy_and_low_memory_decoder_tb
